// >>> core/bsr_pkg.sv
package bsr_pkg;
   localparam int unsigned BSR_ADDR_W = 8;
   localparam int unsigned BSR_DATA_W = 8;
   localparam int unsigned BSR_CODE_W = 6;
   localparam int unsigned BSR_NUM_OUT = 2;

   // register offsets, output a
   localparam logic [7:0] BSR_OFS_OUTA_NORMAL = 8'h3c;
   localparam logic [7:0] BSR_OFS_OUTA_STANDBY = 8'h3d;
   localparam logic [7:0] BSR_OFS_OUTA_SLEEP = 8'h3e;
   localparam logic [7:0] BSR_OFS_OUTA_MODE = 8'h3f;
   localparam logic [7:0] BSR_OFS_OUTA_CONFIG = 8'h40;
   // register offsets, output b
   localparam logic [7:0] BSR_OFS_OUTB_NORMAL = 8'h43;
   localparam logic [7:0] BSR_OFS_OUTB_STANDBY = 8'h44;
   localparam logic [7:0] BSR_OFS_OUTB_SLEEP = 8'h45;
   localparam logic [7:0] BSR_OFS_OUTB_MODE = 8'h46;
   localparam logic [7:0] BSR_OFS_OUTB_CONFIG = 8'h47;
   // distance from output a block to output b block
   localparam logic [7:0] BSR_OFS_B_STRIDE = 8'h07;

   // field positions
   localparam int unsigned BSR_CODE_LSB = 0;
   localparam int unsigned BSR_RANGE_BIT = 6;
   localparam logic [7:0] BSR_SETPOINT_WMASK = 8'h3f;
   localparam logic [7:0] BSR_MODE_WMASK = 8'h2f;
   localparam logic [7:0] BSR_CONFIG_WMASK = 8'hff;

   // reset values
   localparam logic [7:0] BSR_RST_SETPOINT = 8'h00;
   localparam logic [7:0] BSR_RST_MODE = 8'h00;
   localparam logic [7:0] BSR_RST_CONFIG = 8'h00;
   localparam logic BSR_RST_RANGE = 1'b0;

   // voltage ladder in millivolts
   localparam logic [11:0] BSR_LOW_BASE_MV = 12'h190;
   localparam logic [11:0] BSR_LOW_STEP_MV = 12'h019;
   localparam logic [11:0] BSR_HIGH_BASE_MV = 12'h320;
   localparam logic [11:0] BSR_HIGH_STEP_MV = 12'h032;
   // highest usable high-range code; codes above are still applied but clear code_ok
   localparam logic [5:0] BSR_HIGH_MAX_CODE = 6'h32;

   typedef enum logic [2:0] {
      BSR_SEL_NORMAL = 3'b001,
      BSR_SEL_STANDBY = 3'b010,
      BSR_SEL_SLEEP = 3'b100
   } bsr_opmode_t;
endpackage : bsr_pkg

// >>> core/bsr_code_map.sv
`timescale 1ns/1ps
`default_nettype none
// converts a range bit and 6-bit code into millivolts and a validity flag
module bsr_code_map
   import bsr_pkg::*;
(
   // code in
   input wire logic range_hi,
   input wire logic [bsr_pkg::BSR_CODE_W-1:0] code,
   // result
   output logic [11:0] level_mv,
   output logic code_ok
);
   logic [11:0] code_ext;

   assign code_ext = {6'h00, code};

   always_comb begin
      if (range_hi) begin
         level_mv = 12'(BSR_HIGH_BASE_MV + 12'(code_ext * BSR_HIGH_STEP_MV));
         code_ok = (code <= BSR_HIGH_MAX_CODE);
      end else begin
         level_mv = 12'(BSR_LOW_BASE_MV + 12'(code_ext * BSR_LOW_STEP_MV));
         code_ok = 1'b1;
      end
   end
endmodule : bsr_code_map
`default_nettype wire

// >>> core/bsr_out_select.sv
`timescale 1ns/1ps
`default_nettype none
// picks the set point that applies in the current operating mode
module bsr_out_select
   import bsr_pkg::*;
(
   // mode
   input wire bsr_pkg::bsr_opmode_t opmode,
   // stored codes
   input wire logic [bsr_pkg::BSR_CODE_W-1:0] normal_code,
   input wire logic [bsr_pkg::BSR_CODE_W-1:0] standby_code,
   input wire logic [bsr_pkg::BSR_CODE_W-1:0] sleep_code,
   // chosen code
   output logic [bsr_pkg::BSR_CODE_W-1:0] active_code
);
   always_comb begin
      case (opmode)
         BSR_SEL_STANDBY: active_code = standby_code;
         BSR_SEL_SLEEP: active_code = sleep_code;
         BSR_SEL_NORMAL: active_code = normal_code;
         default: active_code = normal_code;
      endcase
   end
endmodule : bsr_out_select
`default_nettype wire

// >>> core/bsr_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - normal set point a: writable code bits 5:0
// - standby code applies only in standby
// - normal range bit read-only, from configuration
// - standby range bit copies normal range bit
// - sleep set point a at 0x3E
// - mode selector a at 0x3F
// - configuration a at 0x40
// - output b registers at 0x43..0x47
// - range 0: 25 mV/0.4 V, range 1: 50 mV/0.8 V
module bsr_regs
   import bsr_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // register port
   input wire logic [bsr_pkg::BSR_ADDR_W-1:0] reg_addr,
   input wire logic [bsr_pkg::BSR_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [bsr_pkg::BSR_DATA_W-1:0] reg_rdata,
   // configuration load of range bits
   input wire logic cfg_load,
   input wire logic [bsr_pkg::BSR_NUM_OUT-1:0] cfg_range,
   // device operating mode
   input wire bsr_pkg::bsr_opmode_t opmode,
   // to regulator, output a
   output logic [bsr_pkg::BSR_CODE_W-1:0] output_a_level,
   output logic output_a_range,
   output logic [11:0] output_a_mv,
   output logic output_a_code_ok,
   output logic [7:0] outa_mode_q,
   output logic [7:0] outa_config_q,
   // to regulator, output b
   output logic [bsr_pkg::BSR_CODE_W-1:0] output_b_level,
   output logic output_b_range,
   output logic [11:0] output_b_mv,
   output logic output_b_code_ok,
   output logic [7:0] outb_mode_q,
   output logic [7:0] outb_config_q
);
   localparam int unsigned NOUT = BSR_NUM_OUT;

   // the address decode and read mux are written for exactly two outputs
   generate
      if (NOUT != 2) begin : g_bad_nout
         $error("bsr_regs serves exactly two outputs");
      end
   endgenerate

   // per-output storage, index 0 = output a, 1 = output b
   logic [BSR_CODE_W-1:0] normal_ff [NOUT];
   logic [BSR_CODE_W-1:0] standby_ff [NOUT];
   logic [BSR_CODE_W-1:0] sleep_ff [NOUT];
   logic [7:0] mode_ff [NOUT];
   logic [7:0] config_ff [NOUT];
   logic [NOUT-1:0] range_ff;
   logic [BSR_DATA_W-1:0] rdata_ff;
   logic [BSR_CODE_W-1:0] active_code [NOUT];
   logic [11:0] mv_w [NOUT];
   logic [NOUT-1:0] ok_w;
   logic [BSR_CODE_W-1:0] level_ff [NOUT];
   logic [11:0] mv_ff [NOUT];
   logic [NOUT-1:0] ok_ff;
   logic [NOUT-1:0] range_out_ff;
   logic [BSR_DATA_W-1:0] nxt_rdata;

   // returns the register slot 0..4 of an address within a block, 7 when unmapped
   function automatic logic [2:0] slot_of(input logic [7:0] addr, input logic [7:0] base);
      logic [7:0] d;
      d = 8'(addr - base);
      if (addr >= base && d <= 8'h04) begin
         slot_of = d[2:0];
      end else begin
         slot_of = 3'h7;
      end
   endfunction : slot_of

   function automatic logic [7:0] block_base(input int unsigned idx);
      block_base = (idx == 0) ? BSR_OFS_OUTA_NORMAL : 8'(BSR_OFS_OUTA_NORMAL + BSR_OFS_B_STRIDE);
   endfunction : block_base

   // range bits: loaded only from configuration, never from the register port
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         range_ff <= {NOUT{BSR_RST_RANGE}};
      end else if (cfg_load) begin
         range_ff <= cfg_range;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NOUT; gi++) begin : g_out
         logic [2:0] slot;
         logic hit_wr;

         assign slot = slot_of(reg_addr, block_base(gi));
         assign hit_wr = reg_wr && (slot != 3'h7);

         always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               normal_ff[gi] <= BSR_RST_SETPOINT[BSR_CODE_W-1:0];
               standby_ff[gi] <= BSR_RST_SETPOINT[BSR_CODE_W-1:0];
               sleep_ff[gi] <= BSR_RST_SETPOINT[BSR_CODE_W-1:0];
            end else if (hit_wr) begin
               case (slot)
                  3'h0: normal_ff[gi] <= reg_wdata[BSR_CODE_W-1:0];
                  3'h1: standby_ff[gi] <= reg_wdata[BSR_CODE_W-1:0];
                  3'h2: sleep_ff[gi] <= reg_wdata[BSR_CODE_W-1:0];
                  default: ;
               endcase
            end
         end

         always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               mode_ff[gi] <= BSR_RST_MODE;
               config_ff[gi] <= BSR_RST_CONFIG;
            end else if (hit_wr) begin
               case (slot)
                  3'h3: mode_ff[gi] <= reg_wdata & BSR_MODE_WMASK;
                  3'h4: config_ff[gi] <= reg_wdata & BSR_CONFIG_WMASK;
                  default: ;
               endcase
            end
         end

         bsr_out_select u_sel (
            .opmode(opmode),
            .normal_code(normal_ff[gi]),
            .standby_code(standby_ff[gi]),
            .sleep_code(sleep_ff[gi]),
            .active_code(active_code[gi])
         );

         bsr_code_map u_map (
            .range_hi(range_ff[gi]),
            .code(active_code[gi]),
            .level_mv(mv_w[gi]),
            .code_ok(ok_w[gi])
         );

         // registered drive toward the analog side
         always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               level_ff[gi] <= BSR_RST_SETPOINT[BSR_CODE_W-1:0];
               mv_ff[gi] <= BSR_LOW_BASE_MV;
               ok_ff[gi] <= 1'b1;
               range_out_ff[gi] <= BSR_RST_RANGE;
            end else begin
               level_ff[gi] <= active_code[gi];
               mv_ff[gi] <= mv_w[gi];
               ok_ff[gi] <= ok_w[gi];
               range_out_ff[gi] <= range_ff[gi];
            end
         end
      end
   endgenerate

   // setpoint read image: bit 7 zero, bit 6 the shared range
   function automatic logic [7:0] sp_image(input logic rng, input logic [BSR_CODE_W-1:0] c);
      sp_image = {1'b0, rng, c};
   endfunction : sp_image

   always_comb begin
      logic [2:0] sa;
      logic [2:0] sb;
      sa = slot_of(reg_addr, block_base(0));
      sb = slot_of(reg_addr, block_base(1));
      nxt_rdata = 8'h00;
      // standby and sleep show the same range bit as normal mode
      case (sa)
         3'h0: nxt_rdata = sp_image(range_ff[0], normal_ff[0]);
         3'h1: nxt_rdata = sp_image(range_ff[0], standby_ff[0]);
         3'h2: nxt_rdata = sp_image(range_ff[0], sleep_ff[0]);
         3'h3: nxt_rdata = mode_ff[0];
         3'h4: nxt_rdata = config_ff[0];
         default: ;
      endcase
      case (sb)
         3'h0: nxt_rdata = sp_image(range_ff[1], normal_ff[1]);
         3'h1: nxt_rdata = sp_image(range_ff[1], standby_ff[1]);
         3'h2: nxt_rdata = sp_image(range_ff[1], sleep_ff[1]);
         3'h3: nxt_rdata = mode_ff[1];
         3'h4: nxt_rdata = config_ff[1];
         default: ;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign reg_rdata = rdata_ff;
   assign output_a_level = level_ff[0];
   assign output_a_range = range_out_ff[0];
   assign output_a_mv = mv_ff[0];
   assign output_a_code_ok = ok_ff[0];
   assign outa_mode_q = mode_ff[0];
   assign outa_config_q = config_ff[0];
   assign output_b_level = level_ff[1];
   assign output_b_range = range_out_ff[1];
   assign output_b_mv = mv_ff[1];
   assign output_b_code_ok = ok_ff[1];
   assign outb_mode_q = mode_ff[1];
   assign outb_config_q = config_ff[1];
endmodule : bsr_regs
`default_nettype wire

// >>> sim/bsr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bsr_checker
   import bsr_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // operating mode
   input wire bsr_pkg::bsr_opmode_t opmode,
   // regulator side
   input wire logic [5:0] output_a_level,
   input wire logic output_a_range,
   input wire logic [11:0] output_a_mv,
   input wire logic output_a_code_ok,
   input wire logic [5:0] output_b_level,
   input wire logic [7:0] outa_mode_q,
   input wire logic [7:0] outa_config_q
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence s_wr(a);
      reg_wr && reg_addr == a;
   endsequence
   // mode must hold through the pipeline, and no rewrite may overtake the first
   sequence s_settle(a, m);
      opmode == m && !(reg_wr && reg_addr == a);
   endsequence
   property p_lvl(a, m, lvl);
      s_wr(a) ##0 opmode == m ##1 s_settle(a, m) |=> {2'h0, lvl} == ($past(reg_wdata, 2) & 8'h3f);
   endproperty
   property p_mv;
      output_a_mv == (output_a_range ? 12'h320 + 12'h032 * output_a_level
                                     : 12'h190 + 12'h019 * output_a_level);
   endproperty
   property p_ok;
      output_a_code_ok == !(output_a_range && output_a_level > 6'h32);
   endproperty
   property p_mode;
      s_wr(8'h3f) |=> outa_mode_q == ($past(reg_wdata) & 8'h2f);
   endproperty
   property p_conf;
      s_wr(8'h40) |=> outa_config_q == $past(reg_wdata);
   endproperty
   property p_rd7;
      reg_rd && reg_addr inside {8'h3c, 8'h3d, 8'h3e} |=> !reg_rdata[7];
   endproperty
   property p_rng;
      reg_rd && reg_addr == 8'h3d |=> reg_rdata[6] == output_a_range;
   endproperty
   a_lvl_norm: assert property (p_lvl(8'h3c, BSR_SEL_NORMAL, output_a_level))
      else $error("normal code not applied");
   a_lvl_stby: assert property (p_lvl(8'h3d, BSR_SEL_STANDBY, output_a_level))
      else $error("standby code not applied");
   a_lvl_sleep: assert property (p_lvl(8'h3e, BSR_SEL_SLEEP, output_a_level))
      else $error("sleep code not applied");
   a_lvl_b: assert property (p_lvl(8'h43, BSR_SEL_NORMAL, output_b_level))
      else $error("output b code not applied");
   a_mv: assert property (p_mv) else $error("millivolt value wrong");
   a_ok: assert property (p_ok) else $error("reserved code flag wrong");
   a_mode: assert property (p_mode) else $error("mode register wrong");
   a_conf: assert property (p_conf) else $error("config register wrong");
   a_rd7: assert property (p_rd7) else $error("unused bit reads one");
   a_rng: assert property (p_rng) else $error("standby range bit differs");
endmodule : bsr_checker
bind bsr_regs bsr_checker u_chk (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .opmode, .output_a_level, .output_a_range, .output_a_mv, .output_a_code_ok,
   .output_b_level, .outa_mode_q, .outa_config_q);
`default_nettype wire

// >>> sim/test_buck_setpoint_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module test_buck_setpoint_regs
   import bsr_pkg::*;
;
   logic clk_sys, nrst, reg_wr, reg_rd, cfg_load, output_a_range, output_b_range;
   logic output_a_code_ok, output_b_code_ok;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, outa_mode_q, outa_config_q, outb_mode_q;
   logic [7:0] outb_config_q;
   logic [1:0] cfg_range;
   logic [5:0] output_a_level, output_b_level;
   logic [11:0] output_a_mv, output_b_mv;
   bsr_opmode_t opmode;
   int error_cnt = 0;
   int comparisons = 0;
   int cycles = 0;
   // address, write data, expected read back
   logic [23:0] rows [12] = '{24'h3c_ff_3f, 24'h3d_c5_05, 24'h3e_2a_2a, 24'h3f_ff_2f,
      24'h40_a5_a5, 24'h41_ff_00, 24'h42_ff_00, 24'h43_3f_3f, 24'h44_11_11, 24'h45_22_22,
      24'h46_21_21, 24'h47_5a_5a};

   bsr_regs uut (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .cfg_load, .cfg_range, .opmode, .output_a_level, .output_a_range, .output_a_mv,
      .output_a_code_ok, .outa_mode_q, .outa_config_q, .output_b_level, .output_b_range,
      .output_b_mv, .output_b_code_ok, .outb_mode_q, .outb_config_q);

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic conclude;
      $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         error_cnt++;
         conclude();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   // read data live only in the cycle after the strobe
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 `CHK(reg_rdata, e)
   endtask : rchk

   // outputs follow one edge after the write task returns; waiting two more costs nothing
   task automatic settle;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask : settle

   task automatic chk_a(input logic [7:0] c, input logic [11:0] mv, input logic ok);
      wr(8'h3c, c);
      settle();
      `CHK(output_a_mv, mv)
      `CHK(output_a_code_ok, ok)
   endtask : chk_a

   initial begin
      nrst = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      cfg_load = 1'b0;
      cfg_range = 2'h0;
      opmode = BSR_SEL_NORMAL;
      repeat (6) @(posedge clk_sys);
      nrst <= 1'b1;
      for (int i = 8'h3c; i <= 8'h47; i++) rchk(i[7:0], 8'h00);
      `CHK(output_a_mv, 12'h190)
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rchk(rows[i][23:16], rows[i][7:0]);
      end
      settle();
      `CHK(output_b_level, 6'h3f)
      `CHK(output_b_mv, 12'h7b7)
      `CHK(output_b_code_ok, 1'b1)
      `CHK(outb_mode_q, 8'h21)
      `CHK(outb_config_q, 8'h5a)
      @(posedge clk_sys);
      opmode <= BSR_SEL_STANDBY;
      wr(8'h3d, 8'h07);
      settle();
      `CHK(output_a_level, 6'h07)
      `CHK(output_b_level, 6'h11)
      @(posedge clk_sys);
      opmode <= BSR_SEL_SLEEP;
      wr(8'h3e, 8'h2b);
      settle();
      `CHK(output_a_level, 6'h2b)
      `CHK(output_b_level, 6'h22)
      @(posedge clk_sys);
      opmode <= BSR_SEL_NORMAL;
      chk_a(8'h2e, 12'h60e, 1'b1);
      chk_a(8'h3f, 12'h7b7, 1'b1);
      @(posedge clk_sys);
      cfg_range <= 2'h3;
      cfg_load <= 1'b1;
      @(posedge clk_sys);
      cfg_load <= 1'b0;
      wr(8'h3c, 8'h80);
      rchk(8'h3c, 8'h40);
      rchk(8'h3d, 8'h47);
      rchk(8'h3e, 8'h6b);
      rchk(8'h44, 8'h51);
      `CHK(output_a_range, 1'b1)
      `CHK(output_b_range, 1'b1)
      chk_a(8'h00, 12'h320, 1'b1);
      chk_a(8'h32, 12'hce4, 1'b1);
      chk_a(8'h33, 12'hd16, 1'b0);
      `CHK(output_b_code_ok, 1'b0)
      `CHK(output_b_mv, 12'hf6e)
      @(posedge clk_sys);
      nrst <= 1'b0;
      settle();
      `CHK(output_a_mv, 12'h190)
      `CHK(output_b_range, 1'b0)
      @(posedge clk_sys);
      nrst <= 1'b1;
      rchk(8'h3c, 8'h00);
      `CHK(output_a_range, 1'b0)
      conclude();
   end
endmodule : test_buck_setpoint_regs
`default_nettype wire
